// ### src/cmd_decode_pkg.sv
// Package: command encodings, power states and timing counts for the command decoder
package cmd_decode_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int BANK_W   = 2;
  localparam int ADDR_W   = 14;
  localparam int NBANK    = 4;
  localparam int PRE_SEL  = 10;   // Index of precharge_select_bit in the address
  localparam int BURST4   = 4;    // Beats in an uninterruptible burst
  localparam int BEAT_W   = 3;

  // ----------------------------------------------------------------
  // Timing counts (clocks)
  // ----------------------------------------------------------------
  localparam int CKE_MIN_CLK      = 3;    // Least clock gate high or low time
  localparam int FREQ_WAIT_CLK    = 2;    // Clocks after gate low before frequency change
  localparam int EXIT_TO_READ_CLK = 200;  // Exit to read delay
  localparam int EXIT_CNT_W       = 8;
  localparam int MIN_CNT_W        = 2;

  // ----------------------------------------------------------------
  // Decoded commands
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    CMD_IDLE       = 4'h0,
    CMD_CONFIG     = 4'h1,
    CMD_REFRESH    = 4'h2,
    CMD_PRE_ONE    = 4'h3,
    CMD_PRE_ALL    = 4'h4,
    CMD_ACTIVATE   = 4'h5,
    CMD_WRITE      = 4'h6,
    CMD_WRITE_AP   = 4'h7,
    CMD_READ       = 4'h8,
    CMD_READ_AP    = 4'h9,
    CMD_SELF_ENTER = 4'ha,
    CMD_PD_ENTER   = 4'hb,
    CMD_EXIT       = 4'hc,
    CMD_ILLEGAL    = 4'hf
  } cmd_t;

  // ----------------------------------------------------------------
  // Power states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    PS_NORMAL     = 3'b000,
    PS_ACTIVE_PD  = 3'b001,
    PS_PRECH_PD   = 3'b010,
    PS_SELF_REF   = 3'b011,
    PS_SR_EXIT    = 3'b100,
    PS_LOST       = 3'b101
  } pstate_t;

endpackage : cmd_decode_pkg

// ### src/cmd_bus_if.sv
// Interface: registered command pins passed from the top to the decoder
`timescale 1ns/1ps
`default_nettype none
interface cmd_bus_if;
  logic                               cs_n;
  logic                               ras_n;
  logic                               cas_n;
  logic                               we_n;
  logic                               cke_prev;
  logic                               cke_cur;
  logic [cmd_decode_pkg::ADDR_W-1:0]  addr;
  cmd_decode_pkg::cmd_t               cmd;

  modport src (output cs_n, ras_n, cas_n, we_n, cke_prev, cke_cur, addr, input cmd);
  modport dec (input cs_n, ras_n, cas_n, we_n, cke_prev, cke_cur, addr, output cmd);
endinterface : cmd_bus_if
`default_nettype wire

// ### src/cmd_truth_decode.sv
// Combinational command truth-table decoder
`timescale 1ns/1ps
`default_nettype none
module cmd_truth_decode (
  cmd_bus_if.dec bus
);

  // ----------------------------------------------------------------
  // Truth table
  // ----------------------------------------------------------------
  // Pattern of cs, ras, cas, we with both gate samples
  always_comb begin
    logic ap;
    ap = bus.addr[cmd_decode_pkg::PRE_SEL];
    bus.cmd = cmd_decode_pkg::CMD_ILLEGAL;
    if (bus.cke_prev && bus.cke_cur) begin
      if (bus.cs_n) begin
        bus.cmd = cmd_decode_pkg::CMD_IDLE;
      end else begin
        case ({bus.ras_n, bus.cas_n, bus.we_n})
          3'b000:  bus.cmd = cmd_decode_pkg::CMD_CONFIG;
          3'b001:  bus.cmd = cmd_decode_pkg::CMD_REFRESH;
          3'b010:  bus.cmd = ap ? cmd_decode_pkg::CMD_PRE_ALL : cmd_decode_pkg::CMD_PRE_ONE;
          3'b011:  bus.cmd = cmd_decode_pkg::CMD_ACTIVATE;
          3'b100:  bus.cmd = ap ? cmd_decode_pkg::CMD_WRITE_AP : cmd_decode_pkg::CMD_WRITE;
          3'b101:  bus.cmd = ap ? cmd_decode_pkg::CMD_READ_AP : cmd_decode_pkg::CMD_READ;
          3'b111:  bus.cmd = cmd_decode_pkg::CMD_IDLE;
          default: bus.cmd = cmd_decode_pkg::CMD_ILLEGAL;
        endcase
      end
    end else if (bus.cke_prev && !bus.cke_cur) begin
      if (bus.cs_n || {bus.ras_n, bus.cas_n, bus.we_n} == 3'b111) begin
        bus.cmd = cmd_decode_pkg::CMD_PD_ENTER;
      end else if ({bus.ras_n, bus.cas_n, bus.we_n} == 3'b001) begin
        bus.cmd = cmd_decode_pkg::CMD_SELF_ENTER;
      end
    end else if (!bus.cke_prev && bus.cke_cur) begin
      if (bus.cs_n || {bus.ras_n, bus.cas_n, bus.we_n} == 3'b111) begin
        bus.cmd = cmd_decode_pkg::CMD_EXIT;
      end
    end else begin
      bus.cmd = cmd_decode_pkg::CMD_IDLE;
    end
  end

endmodule : cmd_truth_decode
`default_nettype wire

// ### src/sdram_cmd_power_decode.sv
// Top: command decoder with bank tracking and clock-gate power states
//
// What this block does
// - Unexpected gate drop loses contents; reinitialisation needed before use.
// - Chip select low with strobes high decodes idle; no action.
// - Idle never stops a running burst.
// - Chip select high is deselect, strobes ignored.
// - Strobe patterns decode config, refresh, precharge, activate, write, read.
// - Precharge select bit picks auto-precharge or all-bank precharge.
// - Bank bits pick target bank or config register.
// - Bursts of four cannot be cut short.
// - Gate high-low with idle enters power-down, or loses contents mid-burst; low-high with idle exits.
// - Refresh with gate falling enters self-refresh from all idle only.
// - No refresh in power-down; controller limits its length.
// - Termination off in self-refresh; never changes decoding.
// - Unlisted gate sequences are illegal and flagged.
// - Low write mask stores data beat; high mask inhibits it.
// - Refresh needs all banks precharged and idle.
`timescale 1ns/1ps
`default_nettype none
module sdram_cmd_power_decode (
  input  wire logic                                ref_clk_i,
  input  wire logic                                rstn_i,
  input  wire logic                                cs_n_i,
  input  wire logic                                ras_n_i,
  input  wire logic                                cas_n_i,
  input  wire logic                                we_n_i,
  input  wire logic                                cke_i,
  input  wire logic [cmd_decode_pkg::BANK_W-1:0]   bank_i,
  input  wire logic [cmd_decode_pkg::ADDR_W-1:0]   addr_i,
  input  wire logic                                termination_control_i,
  input  wire logic                                write_mask_i,
  input  wire logic                                wr_beat_i,
  output logic      [3:0]                          cmd_o,
  output logic      [cmd_decode_pkg::BANK_W-1:0]   cmd_bank_o,
  output logic      [cmd_decode_pkg::ADDR_W-1:0]   cmd_addr_o,
  output logic                                     cmd_valid_o,
  output logic      [cmd_decode_pkg::NBANK-1:0]    bank_open_o,
  output logic      [2:0]                          power_state_o,
  output logic                                     burst_busy_o,
  output logic                                     store_beat_o,
  output logic                                     read_allowed_o,
  output logic                                     termination_on_o,
  output logic                                     contents_lost_o,
  output logic                                     illegal_o
);

  // ----------------------------------------------------------------
  // Input synchronisers (pins come from outside this clock)
  // ----------------------------------------------------------------
  logic [4:0]                         ctl_s1;
  logic [4:0]                         ctl_s2;
  logic [cmd_decode_pkg::BANK_W-1:0]  bank_s1;
  logic [cmd_decode_pkg::BANK_W-1:0]  bank_s2;
  logic [cmd_decode_pkg::ADDR_W-1:0]  addr_s1;
  logic [cmd_decode_pkg::ADDR_W-1:0]  addr_s2;
  logic [2:0]                         aux_s1;
  logic [2:0]                         aux_s2;
  logic                               cke_prev;

  // Two stages; only the second stage feeds logic
  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      ctl_s1  <= 5'h1f;
      ctl_s2  <= 5'h1f;
      bank_s1 <= '0;
      bank_s2 <= '0;
      addr_s1 <= '0;
      addr_s2 <= '0;
      aux_s1  <= 3'h0;
      aux_s2  <= 3'h0;
    end else begin
      ctl_s1  <= {cs_n_i, ras_n_i, cas_n_i, we_n_i, cke_i};
      ctl_s2  <= ctl_s1;
      bank_s1 <= bank_i;
      bank_s2 <= bank_s1;
      addr_s1 <= addr_i;
      addr_s2 <= addr_s1;
      aux_s1  <= {termination_control_i, write_mask_i, wr_beat_i};
      aux_s2  <= aux_s1;
    end
  end

  // Gate level seen at the previous edge
  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      cke_prev <= 1'b1;
    end else begin
      cke_prev <= ctl_s2[0];
    end
  end

  // ----------------------------------------------------------------
  // Truth-table decode
  // ----------------------------------------------------------------
  cmd_bus_if bus ();
  assign bus.cs_n     = ctl_s2[4];
  assign bus.ras_n    = ctl_s2[3];
  assign bus.cas_n    = ctl_s2[2];
  assign bus.we_n     = ctl_s2[1];
  assign bus.cke_cur  = ctl_s2[0];
  assign bus.cke_prev = cke_prev;
  assign bus.addr     = addr_s2;

  cmd_truth_decode u_decode (
    .bus (bus)
  );

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  cmd_decode_pkg::pstate_t                  pstate;
  cmd_decode_pkg::pstate_t                  next_pstate;
  logic [cmd_decode_pkg::NBANK-1:0]         bank_open;
  logic [cmd_decode_pkg::BEAT_W-1:0]        beats_left;
  logic [cmd_decode_pkg::EXIT_CNT_W-1:0]    exit_cnt;
  logic [cmd_decode_pkg::MIN_CNT_W-1:0]     cke_run;
  logic                                     cmd_ok;
  logic                                     seq_bad;
  cmd_decode_pkg::cmd_t                     cmd;

  assign cmd = bus.cmd;

  // Accesses accepted only in normal state; bank-open checks per command
  function automatic logic needs_open(input cmd_decode_pkg::cmd_t c);
    needs_open = (c == cmd_decode_pkg::CMD_WRITE) || (c == cmd_decode_pkg::CMD_WRITE_AP) ||
                 (c == cmd_decode_pkg::CMD_READ)  || (c == cmd_decode_pkg::CMD_READ_AP);
  endfunction : needs_open

  // ----------------------------------------------------------------
  // Power-state machine
  // ----------------------------------------------------------------
  // Gate falls outside the defined entries are taken as content loss
  always_comb begin
    next_pstate = pstate;
    seq_bad     = 1'b0;
    case (pstate)
      cmd_decode_pkg::PS_NORMAL: begin
        if (cmd == cmd_decode_pkg::CMD_PD_ENTER) begin
          if (beats_left != '0) begin
            next_pstate = cmd_decode_pkg::PS_LOST;
          end else begin
            next_pstate = (bank_open != '0) ? cmd_decode_pkg::PS_ACTIVE_PD
                                            : cmd_decode_pkg::PS_PRECH_PD;
          end
        end else if (cmd == cmd_decode_pkg::CMD_SELF_ENTER) begin
          if (bank_open == '0 && beats_left == '0) begin
            next_pstate = cmd_decode_pkg::PS_SELF_REF;
          end else begin
            seq_bad = 1'b1;
          end
        end else if (bus.cke_prev && !bus.cke_cur) begin
          next_pstate = cmd_decode_pkg::PS_LOST;
        end else if (cmd == cmd_decode_pkg::CMD_ILLEGAL) begin
          seq_bad = 1'b1;
        end
      end
      cmd_decode_pkg::PS_ACTIVE_PD,
      cmd_decode_pkg::PS_PRECH_PD: begin
        if (cmd == cmd_decode_pkg::CMD_EXIT) begin
          next_pstate = cmd_decode_pkg::PS_NORMAL;
        end else if (bus.cke_cur) begin
          seq_bad = 1'b1;
        end
      end
      cmd_decode_pkg::PS_SELF_REF: begin
        // Exit taken on gate rise alone; pins other than idle or deselect are flagged
        if (bus.cke_cur) begin
          next_pstate = cmd_decode_pkg::PS_SR_EXIT;
          seq_bad     = (cmd != cmd_decode_pkg::CMD_EXIT);
        end
      end
      cmd_decode_pkg::PS_SR_EXIT: begin
        if (!bus.cke_cur) begin
          next_pstate = cmd_decode_pkg::PS_LOST;
        end else if (exit_cnt == '0) begin
          next_pstate = cmd_decode_pkg::PS_NORMAL;
        end else if (cmd != cmd_decode_pkg::CMD_IDLE) begin
          seq_bad = 1'b1;
        end
      end
      cmd_decode_pkg::PS_LOST: begin
        // Stays until a config write starts reinitialisation
        if (cmd == cmd_decode_pkg::CMD_CONFIG) begin
          next_pstate = cmd_decode_pkg::PS_NORMAL;
        end
      end
      default: next_pstate = cmd_decode_pkg::PS_NORMAL;
    endcase
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      pstate <= cmd_decode_pkg::PS_NORMAL;
    end else begin
      pstate <= next_pstate;
    end
  end

  assign cmd_ok = (pstate == cmd_decode_pkg::PS_NORMAL);

  // ----------------------------------------------------------------
  // Open-bank tracking
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i || pstate == cmd_decode_pkg::PS_LOST) begin
      bank_open <= '0;
    end else if (cmd_ok) begin
      case (cmd)
        cmd_decode_pkg::CMD_ACTIVATE:  bank_open[bank_s2] <= 1'b1;
        cmd_decode_pkg::CMD_PRE_ONE:   bank_open[bank_s2] <= 1'b0;
        cmd_decode_pkg::CMD_PRE_ALL:   bank_open <= '0;
        cmd_decode_pkg::CMD_WRITE_AP,
        cmd_decode_pkg::CMD_READ_AP:   bank_open[bank_s2] <= 1'b0;
        default:                       bank_open <= bank_open;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Burst of four: runs to the end regardless of idle commands
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      beats_left <= '0;
    end else if (beats_left != '0) begin
      beats_left <= beats_left - 1'b1;
    end else if (cmd_ok && needs_open(cmd) && bank_open[bank_s2]) begin
      beats_left <= cmd_decode_pkg::BEAT_W'(cmd_decode_pkg::BURST4);
    end
  end

  // ----------------------------------------------------------------
  // Self-refresh exit counter and gate run-length
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      exit_cnt <= '0;
    end else if (pstate == cmd_decode_pkg::PS_SELF_REF) begin
      exit_cnt <= cmd_decode_pkg::EXIT_CNT_W'(cmd_decode_pkg::EXIT_TO_READ_CLK - 1);
    end else if (exit_cnt != '0) begin
      exit_cnt <= exit_cnt - 1'b1;
    end
  end

  // Run length of the gate level, saturating at the minimum
  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      cke_run <= cmd_decode_pkg::MIN_CNT_W'(cmd_decode_pkg::CKE_MIN_CLK);
    end else if (bus.cke_cur != cke_prev) begin
      cke_run <= cmd_decode_pkg::MIN_CNT_W'(1);
    end else if (cke_run != cmd_decode_pkg::MIN_CNT_W'(cmd_decode_pkg::CKE_MIN_CLK)) begin
      cke_run <= cke_run + 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      cmd_o        <= 4'h0;
      cmd_bank_o   <= '0;
      cmd_addr_o   <= '0;
      cmd_valid_o  <= 1'b0;
      illegal_o    <= 1'b0;
      store_beat_o <= 1'b0;
    end else begin
      cmd_o        <= cmd;
      cmd_bank_o   <= bank_s2;
      cmd_addr_o   <= addr_s2;
      cmd_valid_o  <= cmd_ok && cmd != cmd_decode_pkg::CMD_IDLE
                      && cmd != cmd_decode_pkg::CMD_ILLEGAL;
      // Too short a gate level, refresh with open bank, access to a closed bank, or bad sequence
      illegal_o    <= seq_bad
                      || (bus.cke_cur != cke_prev
                          && cke_run != cmd_decode_pkg::MIN_CNT_W'(cmd_decode_pkg::CKE_MIN_CLK))
                      || (cmd_ok && cmd == cmd_decode_pkg::CMD_REFRESH && bank_open != '0)
                      || (cmd_ok && needs_open(cmd) && !bank_open[bank_s2]);
      store_beat_o <= aux_s2[0] && !aux_s2[1];
    end
  end

  assign bank_open_o      = bank_open;
  assign power_state_o    = pstate;
  assign burst_busy_o     = (beats_left != '0);
  assign read_allowed_o   = cmd_ok;
  // Termination never feeds the decoder; forced off in self-refresh
  assign termination_on_o = aux_s2[2] && pstate != cmd_decode_pkg::PS_SELF_REF;
  assign contents_lost_o  = (pstate == cmd_decode_pkg::PS_LOST);

endmodule : sdram_cmd_power_decode
`default_nettype wire

// ### tb/ctrl_model.sv
// Memory controller model driving the command, gate and data pins
`timescale 1ns/1ps
`default_nettype none
module ctrl_model (
  input  wire logic        clk_i,
  output logic      [3:0]  pins_o,
  output logic             cke_o,
  output logic      [1:0]  bank_o,
  output logic      [13:0] addr_o,
  output logic             term_o,
  output logic             mask_o,
  output logic             beat_o
);
  // Pins idle and gate high from time zero
  initial begin
    pins_o = 4'hf;
    cke_o  = 1'b1;
    bank_o = 2'h0;
    addr_o = 14'h0;
    term_o = 1'b0;
    mask_o = 1'b0;
    beat_o = 1'b0;
  end

  // One command a clock, changed just after the falling edge, held a whole cycle
  task automatic put(input logic [3:0] p, input logic k, input logic [1:0] b,
                     input logic [13:0] a);
    pins_o = p;
    cke_o  = k;
    bank_o = b;
    addr_o = p[3] ? ~addr_o : a;      // Deselected: address is not held
    @(negedge clk_i);
  endtask : put

  // Data side levels, held until changed
  task automatic data(input logic t, input logic m, input logic w);
    term_o = t;
    mask_o = m;
    beat_o = w;
  endtask : data
endmodule : ctrl_model
`default_nettype wire

// ### tb/sdram_cmd_power_decode_assertions.sv
// Checker: decode, bank tracking and power state relations at the top ports
`timescale 1ns/1ps
`default_nettype none
module sdram_cmd_power_decode_assertions (
  input wire logic        ref_clk_i,
  input wire logic        rstn_i,
  input wire logic        cs_n_i,
  input wire logic        ras_n_i,
  input wire logic        cas_n_i,
  input wire logic        we_n_i,
  input wire logic        cke_i,
  input wire logic [13:0] addr_i,
  input wire logic        write_mask_i,
  input wire logic        wr_beat_i,
  input wire logic [3:0]  cmd_o,
  input wire logic [1:0]  cmd_bank_o,
  input wire logic        cmd_valid_o,
  input wire logic [3:0]  bank_open_o,
  input wire logic [2:0]  power_state_o,
  input wire logic        burst_busy_o,
  input wire logic        store_beat_o,
  input wire logic        termination_on_o,
  input wire logic        contents_lost_o
);
  // ----------------
  // Pin patterns
  // ----------------
  logic idle_pin;
  logic rd_pin;
  logic st_pin;
  // Decoded three edges later, so the pins are kept as plain signals for $past
  assign idle_pin = cs_n_i | (ras_n_i & cas_n_i & we_n_i);
  assign rd_pin   = ~cs_n_i & ras_n_i & ~cas_n_i & we_n_i & ~addr_i[10];
  assign st_pin   = wr_beat_i & ~write_mask_i;

  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!rstn_i);

  chk_idle_no_cmd: assert property (
    $past(rstn_i, 3) && $past(idle_pin, 3) && $past(cke_i, 3) == $past(cke_i, 4)
    |-> !cmd_valid_o)
    else $error("idle cycle produced a command");
  chk_read_pattern: assert property (
    cmd_valid_o && cmd_o == cmd_decode_pkg::CMD_READ |-> $past(rd_pin, 3))
    else $error("read decoded from wrong pins");
  chk_act_opens: assert property (
    cmd_valid_o && cmd_o == cmd_decode_pkg::CMD_ACTIVATE |-> bank_open_o[cmd_bank_o])
    else $error("activated bank not open");
  chk_preall_closes: assert property (
    cmd_valid_o && cmd_o == cmd_decode_pkg::CMD_PRE_ALL |-> bank_open_o == 4'h0)
    else $error("banks open after precharge all");
  chk_burst_four: assert property (
    $rose(burst_busy_o) |-> burst_busy_o[*4])
    else $error("burst shorter than four");
  chk_mask_store: assert property (
    $past(rstn_i, 3) |-> store_beat_o == $past(st_pin, 3))
    else $error("store beat does not follow mask");
  chk_pd_kind: assert property (
    $changed(power_state_o) && power_state_o inside {cmd_decode_pkg::PS_ACTIVE_PD,
    cmd_decode_pkg::PS_PRECH_PD} |->
    (power_state_o == cmd_decode_pkg::PS_PRECH_PD) == (bank_open_o == 4'h0))
    else $error("wrong power-down kind");
  chk_self_idle: assert property (
    $changed(power_state_o) && power_state_o == cmd_decode_pkg::PS_SELF_REF
    |-> $past(bank_open_o) == 4'h0)
    else $error("self refresh with open bank");
  chk_term_self: assert property (
    power_state_o == cmd_decode_pkg::PS_SELF_REF |-> !termination_on_o)
    else $error("termination on in self refresh");
  chk_lost_flag: assert property (
    power_state_o == cmd_decode_pkg::PS_LOST |-> contents_lost_o)
    else $error("lost state without flag");
endmodule : sdram_cmd_power_decode_assertions

bind sdram_cmd_power_decode sdram_cmd_power_decode_assertions i_chk (
  .ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .cs_n_i(cs_n_i), .ras_n_i(ras_n_i),
  .cas_n_i(cas_n_i), .we_n_i(we_n_i), .addr_i(addr_i), .write_mask_i(write_mask_i),
  .wr_beat_i(wr_beat_i), .cmd_o(cmd_o), .cmd_bank_o(cmd_bank_o), .cmd_valid_o(cmd_valid_o),
  .bank_open_o(bank_open_o), .power_state_o(power_state_o), .burst_busy_o(burst_busy_o),
  .store_beat_o(store_beat_o), .termination_on_o(termination_on_o),
  .contents_lost_o(contents_lost_o), .cke_i(cke_i));
`default_nettype wire

// ### tb/tb_top.sv
// Testbench: command decoder driven by the controller model
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  // Entry: pins, precharge select bit, bank, expected code
  localparam logic [10:0] DEC_TBL [14] = '{
    11'b0011_0_01_0101, 11'b0100_0_01_0110, 11'b0101_0_01_1000, 11'b0101_1_01_1001,
    11'b0011_0_10_0101, 11'b0100_1_10_0111, 11'b0011_0_11_0101, 11'b0010_0_11_0011,
    11'b0011_0_00_0101, 11'b0010_1_00_0100, 11'b0001_0_00_0010, 11'b0000_0_01_0001,
    11'b0111_0_00_0000, 11'b1011_0_00_0000};
  logic        ref_clk_i;
  logic        rstn_i;
  logic [3:0]  pins;
  logic        cke;
  logic [1:0]  bank;
  logic [13:0] addr;
  logic        term;
  logic        mask;
  logic        beat;
  logic [3:0]  code;
  logic [1:0]  code_bank;
  logic [13:0] code_addr;
  logic        valid;
  logic [3:0]  bopen;
  logic [2:0]  pstate;
  logic        busy;
  logic        store;
  logic        rd_ok;
  logic        term_on;
  logic        lost;
  logic        illegal;
  int          mismatches;
  int          checks_done;

  ctrl_model i_ctrl_model (
    .clk_i(ref_clk_i), .pins_o(pins), .cke_o(cke), .bank_o(bank), .addr_o(addr),
    .term_o(term), .mask_o(mask), .beat_o(beat));
  sdram_cmd_power_decode i_sdram_cmd_power_decode (
    .ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .cs_n_i(pins[3]), .ras_n_i(pins[2]),
    .cas_n_i(pins[1]), .we_n_i(pins[0]), .cke_i(cke), .bank_i(bank), .addr_i(addr),
    .termination_control_i(term), .write_mask_i(mask), .wr_beat_i(beat),
    .cmd_o(code), .cmd_bank_o(code_bank), .cmd_addr_o(code_addr), .cmd_valid_o(valid),
    .bank_open_o(bopen), .power_state_o(pstate), .burst_busy_o(busy),
    .store_beat_o(store), .read_allowed_o(rd_ok), .termination_on_o(term_on),
    .contents_lost_o(lost), .illegal_o(illegal));

  // 200 MHz clock
  initial begin
    ref_clk_i = 1'b0;
    forever #2.5 ref_clk_i = ~ref_clk_i;
  end

  // ----------------
  // Shared tasks
  // ----------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask : chk
  task automatic nop(input int n, input logic k);
    repeat (n) i_ctrl_model.put(4'h7, k, 2'h0, 14'h0);
  endtask : nop
  task automatic cmd(input logic [3:0] p, input logic [1:0] b, input logic a10);
    i_ctrl_model.put(p, 1'b1, b, {3'h0, a10, 10'h0});
  endtask : cmd
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : print_verdict

  // ----------------
  // Scenarios
  // ----------------
  // Every gate-high command code, idle and deselect, with a bank model kept alongside
  task automatic t_decode;
    logic [10:0] e;
    logic [3:0]  eb;
    eb = 4'h0;
    for (int i = 0; i < 14; i++) begin
      e = DEC_TBL[i];
      cmd(e[10:7], e[5:4], e[6]);
      nop(2, 1'b1);
      chk(code, e[3:0], "decoded code");
      if (!e[10]) chk(code_addr, {3'h0, e[6], 10'h0}, "address");
      chk(valid, e[3:0] != 4'h0, "valid pulse");
      if (e[3:0] inside {4'h1, 4'h3, 4'h5, 4'h6, 4'h8}) chk(code_bank, e[5:4], "bank");
      if (e[3:0] == 4'h5) eb[e[5:4]] = 1'b1;
      if (e[3:0] inside {4'h3, 4'h7, 4'h9}) eb[e[5:4]] = 1'b0;
      if (e[3:0] == 4'h4) eb = 4'h0;
      chk(bopen, eb, "open banks");
      nop(3, 1'b1);
      if (e[3:0] inside {4'h6, 4'h7}) chk(busy, 1'b1, "burst cut by idle");
      nop(2, 1'b1);
    end
    $display("decode test done");
  endtask : t_decode

  // All four mask and beat combinations
  task automatic t_mask;
    for (int i = 0; i < 4; i++) begin
      i_ctrl_model.data(i[1], i[0], i[1]);
      nop(1, 1'b1);
      i_ctrl_model.data(1'b0, 1'b0, 1'b0);
      nop(1, 1'b1);
      chk(term_on, i[1], "termination pass");
      nop(1, 1'b1);
      chk(store, i[1] & ~i[0], "store beat");
      nop(1, 1'b1);
    end
    $display("mask test done");
  endtask : t_mask

  // Active then precharge power-down; pins ignored while the gate stays low
  task automatic t_power;
    cmd(4'h3, 2'h2, 1'b0);
    nop(5, 1'b1);
    nop(4, 1'b0);
    chk(pstate, 3'd1, "active power-down");
    i_ctrl_model.put(4'h3, 1'b0, 2'h1, 14'h0);
    nop(2, 1'b0);
    chk(valid, 1'b0, "command in power-down");
    nop(1, 1'b0);
    chk(bopen, 4'h4, "bank opened in power-down");
    nop(4, 1'b1);
    chk(pstate, 3'd0, "power-down exit");
    cmd(4'h2, 2'h0, 1'b1);
    nop(5, 1'b1);
    nop(4, 1'b0);
    chk(pstate, 3'd2, "precharge power-down");
    nop(4, 1'b1);
    chk(pstate, 3'd0, "precharge power-down exit");
    $display("power-down test done");
  endtask : t_power

  // Self refresh entry, masked termination, early read in the exit window
  task automatic t_self;
    i_ctrl_model.put(4'h1, 1'b0, 2'h0, 14'h0);
    nop(3, 1'b0);
    chk(pstate, 3'd3, "self refresh entry");
    i_ctrl_model.data(1'b1, 1'b0, 1'b0);
    nop(4, 1'b0);
    chk(term_on, 1'b0, "termination in self refresh");
    i_ctrl_model.data(1'b0, 1'b0, 1'b0);
    nop(4, 1'b1);
    chk(pstate, 3'd4, "self refresh exit");
    chk(rd_ok, 1'b0, "read allowed too early");
    cmd(4'h5, 2'h0, 1'b0);
    nop(2, 1'b1);
    chk(illegal, 1'b1, "read in exit window");
    nop(195, 1'b1);
    chk(rd_ok, 1'b0, "read window short");
    nop(1, 1'b1);
    chk(rd_ok, 1'b1, "read window long");
    $display("self refresh test done");
  endtask : t_self

  // Gate low for one clock only
  task automatic t_short;
    logic seen;
    seen = 1'b0;
    nop(1, 1'b0);
    repeat (6) begin
      nop(1, 1'b1);
      seen = seen | illegal;
    end
    chk(seen, 1'b1, "short gate low");
    nop(4, 1'b1);
    $display("short gate test done");
  endtask : t_short

  // Gate drop under a write, then recovery by a config write
  task automatic t_lost;
    cmd(4'h3, 2'h0, 1'b0);
    nop(5, 1'b1);
    i_ctrl_model.put(4'h4, 1'b0, 2'h0, 14'h0);
    nop(3, 1'b0);
    chk(lost, 1'b1, "gate drop flag");
    chk(pstate, 3'd5, "contents lost state");
    nop(3, 1'b0);
    nop(4, 1'b1);
    cmd(4'h0, 2'h0, 1'b0);
    nop(3, 1'b1);
    chk(pstate, 3'd0, "reinit leaves lost state");
    $display("gate drop test done");
  endtask : t_lost

  // Reset for five clocks, then the scenarios in turn
  initial begin
    rstn_i = 1'b0;
    mismatches = 0;
    checks_done = 0;
    repeat (5) @(negedge ref_clk_i);
    rstn_i = 1'b1;
    nop(2, 1'b1);
    t_decode;
    t_mask;
    t_power;
    t_self;
    t_short;
    t_lost;
    print_verdict;
  end

  // Watchdog: the run needs about 410 clocks
  initial begin
    #20000;
    mismatches++;
    print_verdict;
  end
endmodule : tb_top
`default_nettype wire
